// ### dv/ddrp_ctrl_model.sv
/* Memory controller model: free-running CK, commands and write beats.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module ddrp_ctrl_model (
  // Link clock and command pins
  output logic        linkClk,
  output logic        cke,
  output logic        csN,
  output logic        rasN,
  output logic        casN,
  output logic        weN,
  output logic [1:0]  ba,
  output logic [12:0] addr,
  // Write data and masks
  output logic [15:0] dqInRise,
  output logic [15:0] dqInFall,
  output logic [1:0]  dmInRise,
  output logic [1:0]  dmInFall
);
  // CK runs free, as a DDR controller keeps it; the offset keeps its edges off clk_sys edges
  initial begin
    linkClk = 1'b0;
    #10;
    forever #62.5 linkClk = ~linkClk;
  end
  // Idle pins at time zero
  initial begin
    cke = 1'b0;
    {csN, rasN, casN, weN} = 4'hF;
    {ba, addr} = 15'h0;
    {dqInRise, dqInFall, dmInRise, dmInFall} = 36'h0;
  end
  task automatic setCke(input logic v);
    @(negedge linkClk);
    cke = v;
  endtask
  // One command, then two write beats; pins change mid-cycle so they stay centred
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                     input logic [31:0] d0, d1, input logic [3:0] m0, m1);
    @(negedge linkClk);
    {csN, rasN, casN, weN} = c;
    ba = b;
    addr = a;
    @(negedge linkClk);
    {csN, rasN, casN, weN} = 4'hF;
    ba = ~b; // Released lines show no stale value
    addr = ~a;
    {dqInRise, dqInFall} = d0;
    {dmInRise, dmInFall} = m0;
    @(negedge linkClk);
    {dqInRise, dqInFall} = d1;
    {dmInRise, dmInFall} = m1;
    @(negedge linkClk);
    {dqInRise, dqInFall} = ~d1;
    {dmInRise, dmInFall} = ~m1;
  endtask
endmodule

// ### dv/ddrp_pin_decode_props.sv
/* Port checker for the DDR pin decoder.
   Assumes cke stays low while reset is held. */
`timescale 1ns/1ps
module ddrp_pin_decode_props (
  // Clocks and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        linkClk,
  // Command pins
  input wire logic        cke,
  input wire logic        csN,
  input wire logic        rasN,
  input wire logic        casN,
  input wire logic        weN,
  input wire logic [1:0]  ba,
  input wire logic [12:0] addr,
  // Link outputs
  input wire logic [1:0]  dqOe,
  input wire logic [1:0]  dqsOutRise,
  input wire logic [1:0]  dqsOutFall,
  input wire logic [1:0]  dqsOe,
  input wire logic [3:0]  bankOpen,
  // Event stream
  input wire logic        evValid,
  input wire logic        evBeat,
  input wire ddrp_pkg::ddrp_kind_t evKind,
  input wire logic [12:0] evAddr,
  input wire logic [31:0] evData,
  input wire logic [3:0]  evByteEn
);
  import ddrp_pkg::*;
  logic [2:0]  rstQ;
  logic        ckeQ;
  logic        lRst;
  logic        isOpen;
  logic        isPre;
  logic [31:0] keep;
  // Link reset lags sys_rst by two flops, so hold checks off through a three-flop release
  always_ff @(posedge linkClk) begin
    rstQ <= {rstQ[1:0], sys_rst};
    ckeQ <= cke & ~sys_rst;
  end
  // Decoded command classes and byte keep mask
  assign lRst = sys_rst | (|rstQ);
  assign isOpen = ckeQ & ~csN & ~rasN & casN & weN;
  assign isPre = ckeQ & ~csN & ~rasN & casN & ~weN;
  assign keep = {{8{evByteEn[3]}}, {8{evByteEn[2]}}, {8{evByteEn[1]}}, {8{evByteEn[0]}}};

  a_open_sets_bank: assert property (@(posedge linkClk) disable iff (lRst)
    isOpen |=> bankOpen[$past(ba)]) else $error("row open left bank closed");
  a_pre_clears_bank: assert property (@(posedge linkClk) disable iff (lRst)
    isPre && !addr[AP_BIT] |=> !bankOpen[$past(ba)]) else $error("precharge left bank open");
  a_preall_clears: assert property (@(posedge linkClk) disable iff (lRst)
    isPre && addr[AP_BIT] |=> bankOpen == 4'h0) else $error("precharge all left a bank open");
  a_deselect_masks: assert property (@(posedge linkClk) disable iff (lRst)
    ckeQ && csN |=> $stable(bankOpen)) else $error("deselected command acted on");
  a_cke_freezes: assert property (@(posedge linkClk) disable iff (lRst)
    !ckeQ |=> $stable(bankOpen) && $stable(dqOe)) else $error("state moved with cke low");
  a_read_strobe: assert property (@(posedge linkClk) disable iff (lRst)
    dqOe != 2'h0 |-> dqOe == 2'h3 && dqsOe == 2'h3 && dqsOutRise == 2'h3 && dqsOutFall == 2'h0)
    else $error("read strobe not aligned with data");
  a_mask_zeroes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evValid && evBeat |-> (evData & ~keep) == 32'h0) else $error("masked byte passed through");
  a_col_no_a11: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evValid && !evBeat && (evKind == KIND_RD || evKind == KIND_WR) |-> !evAddr[COL_LO_W])
    else $error("column used A11");
endmodule

bind ddrp_pin_decode ddrp_pin_decode_props ddrp_pin_decode_props_i (.*);

// ### dv/tb_ddrp_pin_decode.sv
/* Bench for the DDR pin decoder with a controller model and a core stand-in.
   Assumes x16 build and a 16-entry event FIFO. */
`timescale 1ns/1ps
module tb_ddrp_pin_decode;
  import ddrp_pkg::*;
  localparam logic [3:0] OPEN = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4;
  logic        clk_sys, sys_rst, evReady, rdValid, rdReady, linkStall, evValid, evBeat, evAutoPre;
  logic        linkClk, cke, csN, rasN, casN, weN;
  logic [1:0]  ba, dmInRise, dmInFall, dqOe, dqsOutRise, dqsOutFall, dqsOe, evBank;
  logic [12:0] addr, evAddr;
  logic [15:0] dqInRise, dqInFall, dqOutRise, dqOutFall;
  logic [3:0]  bankOpen, evByteEn;
  logic [31:0] rdData, evData;
  ddrp_kind_t  evKind;
  int          n_errors, samples_checked, cyc;

  ddrp_ctrl_model ddrp_ctrl_model_i (.*);
  ddrp_pin_decode ddrp_pin_decode_i (.*);

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic waitEv;
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 400 && evValid !== 1'b1; i++) @(negedge clk_sys);
    chk(32'(evValid), 32'h1);
  endtask
  task automatic takeEv;
    evReady = 1'b1;
    @(negedge clk_sys);
    evReady = 1'b0;
  endtask
  // Command event; address and auto-precharge only where they mean something
  task automatic expEv(input ddrp_kind_t k, input logic [1:0] b, input logic [12:0] a,
                       input logic ap);
    waitEv();
    chk(32'(evKind), 32'(k));
    chk(32'(evBank), 32'(b));
    if (k != KIND_PRE && k != KIND_PREALL) chk(32'(evAddr), 32'(a));
    if (k == KIND_RD || k == KIND_WR) chk(32'(evAutoPre), 32'(ap));
    takeEv();
  endtask
  task automatic beatEv(input logic [31:0] d, input logic [3:0] be);
    waitEv();
    chk(32'(evBeat), 32'h1);
    chk(evData, d);
    chk(32'(evByteEn), 32'(be));
    takeEv();
  endtask
  task automatic pushRd(input logic [31:0] w);
    int i;
    @(negedge clk_sys);
    rdValid = 1'b1;
    rdData = w;
    // Ready is read off the edge so its own update cannot race the check
    for (i = 0; i < 50 && rdReady !== 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    rdValid = 1'b0;
  endtask
  task automatic doReset;
    ddrp_ctrl_model_i.setCke(1'b0);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(32'({bankOpen, evValid, rdReady}), 32'h0);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk(32'(rdReady), 32'h1);
    ddrp_ctrl_model_i.setCke(1'b1);
    ddrp_ctrl_model_i.setCke(1'b1);
  endtask
  // Deselected open, then an open behind a low clock enable
  task automatic tIgnore;
    ddrp_ctrl_model_i.cmd(4'hB, 2'h0, 13'h0, 32'h0, 32'h0, 4'h0, 4'h0);
    ddrp_ctrl_model_i.setCke(1'b0);
    ddrp_ctrl_model_i.cmd(OPEN, 2'h0, 13'h0, 32'h0, 32'h0, 4'h0, 4'h0);
    ddrp_ctrl_model_i.setCke(1'b1);
    repeat (20) @(negedge clk_sys);
    chk(32'({bankOpen, evValid}), 32'h0);
  endtask
  // Open every bank with edge-case rows
  task automatic tOpen;
    logic [12:0] rows[4] = '{13'h1FFF, 13'h0000, 13'h1555, 13'h0AAA};
    for (int b = 0; b < 4; b++) begin
      ddrp_ctrl_model_i.cmd(OPEN, 2'(b), rows[b], 32'h0, 32'h0, 4'h0, 4'h0);
      expEv(KIND_OPEN, 2'(b), rows[b], 1'b0);
    end
    chk(32'(bankOpen), 32'hF);
  endtask
  // Write with A11 and A10 set and a different lane mask per beat
  task automatic tWrite;
    ddrp_ctrl_model_i.cmd(WR, 2'h1, 13'h0FFF, 32'h11223344, 32'hA5C30F96, 4'h5, 4'hA);
    expEv(KIND_WR, 2'h1, 13'h03FF, 1'b1);
    beatEv(32'h11003300, 4'hA);
    beatEv(32'h00C30096, 4'h5);
    chk(32'(bankOpen), 32'hD);
  endtask
  // Read burst of two preloaded words, high half on the rising edge
  task automatic tRead;
    logic [31:0] q[$];
    pushRd(32'hDEADBEEF);
    pushRd(32'h01234567);
    fork
      ddrp_ctrl_model_i.cmd(RD, 2'h2, 13'h0155, 32'h0, 32'hF, 4'h0, 4'hF);
      for (int i = 0; i < 12; i++) begin
        @(negedge linkClk);
        if (dqOe === 2'h3) begin
          q.push_back({dqOutRise, dqOutFall});
          chk(32'({dqsOutRise, dqsOutFall, dqsOe}), 32'h33);
        end
      end
    join
    chk(32'(q.size()), 32'h2);
    chk(q[0], 32'hDEADBEEF);
    chk(q[1], 32'h01234567);
    expEv(KIND_RD, 2'h2, 13'h0155, 1'b0);
  endtask
  // Single-bank then all-bank precharge
  task automatic tPre;
    ddrp_ctrl_model_i.cmd(PRE, 2'h3, 13'h0000, 32'h0, 32'h0, 4'h0, 4'h0);
    expEv(KIND_PRE, 2'h3, 13'h0, 1'b0);
    chk(32'(bankOpen), 32'h5);
    ddrp_ctrl_model_i.cmd(PRE, 2'h0, 13'h0400, 32'h0, 32'h0, 4'h0, 4'h0);
    expEv(KIND_PREALL, 2'h0, 13'h0, 1'b0);
    chk(32'(bankOpen), 32'h0);
  endtask
  // Core stalls until the event FIFO refuses, then drains it
  task automatic tFill;
    int n;
    for (int i = 0; i < 18; i++)
      ddrp_ctrl_model_i.cmd(OPEN, 2'h0, 13'(i), 32'h0, 32'h0, 4'h0, 4'h0);
    chk(32'(linkStall), 32'h1);
    n = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_sys);
      evReady = evValid;
      if (evValid === 1'b1) n++;
    end
    evReady = 1'b0;
    chk(32'(n), 32'(FIFO_DEPTH + 1)); // Buffer plus the word held at the output
    chk(32'(linkStall), 32'h0);
  endtask
  // Main sequence, with a second reset in mid-run
  initial begin
    {sys_rst, evReady, rdValid, rdData} = 35'h400000000; // Reset held from time zero
    {n_errors, samples_checked, cyc} = '0;
    doReset();
    tIgnore();
    tOpen();
    tWrite();
    tRead();
    tPre();
    doReset();
    tFill();
    summarize();
  end
endmodule

// ### verilog/ddrp_pin_decode.sv
/*
  DDR SDRAM pin-level command decoder, data strobes and write masking, plus
  the dual-clock FIFO that carries events and read data across clocks.
  Assumes pad cells present rise/fall data halves already aligned to CK,
  and a core on clk_sys that consumes events and supplies read words.
*/
// Functional notes
// RL1: Row open captures all thirteen address bits.
// RL2: Column from low bits, A10 selects auto-precharge.
// RL3: x16 organisation ignores A11 in columns.
// RL4: Chip select high masks every command.
// RL5: Controller treats chip select as command bit.
// RL6: Strobes latched on CK rise, decoded together.
// RL7: Row strobe alone low opens addressed bank.
// RL8: Row strobe and write low precharge bank.
// RL9: Column strobe low: read or write by WE.
// RL10: Read strobe edge aligned; write strobe centred.
// RL11: Lower strobe times low byte, upper high.
// RL12: Masked write beats leave stored byte unchanged.
// RL13: Each mask input governs its own byte.
// RL14: One data beat per strobe edge.
// RL15: Low clock enable freezes state next cycle.
// RL16: Bank select picks one of four banks.
// RL17: Controller accesses only banks already opened.
// RL18: Each mask sample covers its own beat.
`timescale 1ns/1ps

module ddrp_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Write side
  input  wire logic             wClk,
  input  wire logic             wRst,
  input  wire logic             wValid,
  input  wire logic [WIDTH-1:0] wData,
  output logic                  wReady,
  // Read side
  input  wire logic             rClk,
  input  wire logic             rRst,
  input  wire logic             rReady,
  output logic                  rValid,
  output logic      [WIDTH-1:0] rData
);
  import ddrp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wBin_reg, wBin_next, wGray_reg, wGray_next;
  logic [AW:0]      rBin_reg, rBin_next, rGray_reg, rGray_next;
  logic [AW:0]      rGrayS1_reg, rGrayS2_reg, wGrayS1_reg, wGrayS2_reg;
  logic             wReady_reg, wReady_next, rValid_reg, rValid_next;
  logic             wPush, rPop;

  assign wReady = wReady_reg;
  assign rValid = rValid_reg;
  assign rData  = mem[rBin_reg[AW-1:0]];

  // Write pointer; full when gray pointers differ only in the top two bits
  always_comb begin
    wPush       = wValid && wReady_reg;
    wBin_next   = wBin_reg + (AW+1)'(wPush);
    wGray_next  = (AW+1)'(ddrp_bin2gray(5'(wBin_next)));
    wReady_next = wGray_next != {~rGrayS2_reg[AW:AW-1], rGrayS2_reg[AW-2:0]};
  end

  always_ff @(posedge wClk) begin
    if (wRst) begin
      wBin_reg    <= '0;
      wGray_reg   <= '0;
      wReady_reg  <= 1'b0;
      rGrayS1_reg <= '0;
      rGrayS2_reg <= '0;
    end else begin
      wBin_reg    <= wBin_next;
      wGray_reg   <= wGray_next;
      wReady_reg  <= wReady_next;
      rGrayS1_reg <= rGray_reg;
      rGrayS2_reg <= rGrayS1_reg;
      if (wPush) begin
        mem[wBin_reg[AW-1:0]] <= wData;
      end
    end
  end

  // Read pointer; empty when gray pointers match
  always_comb begin
    rPop        = rReady && rValid_reg;
    rBin_next   = rBin_reg + (AW+1)'(rPop);
    rGray_next  = (AW+1)'(ddrp_bin2gray(5'(rBin_next)));
    rValid_next = rGray_next != wGrayS2_reg;
  end

  always_ff @(posedge rClk) begin
    if (rRst) begin
      rBin_reg    <= '0;
      rGray_reg   <= '0;
      rValid_reg  <= 1'b0;
      wGrayS1_reg <= '0;
      wGrayS2_reg <= '0;
    end else begin
      rBin_reg    <= rBin_next;
      rGray_reg   <= rGray_next;
      rValid_reg  <= rValid_next;
      wGrayS1_reg <= wGray_reg;
      wGrayS2_reg <= wGrayS1_reg;
    end
  end
endmodule

module ddrp_pin_decode (
  // System clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // Link clock and command pins
  input  wire logic                          linkClk,
  input  wire logic                          cke,
  input  wire logic                          csN,
  input  wire logic                          rasN,
  input  wire logic                          casN,
  input  wire logic                          weN,
  input  wire logic [ddrp_pkg::BANK_W-1:0]   ba,
  input  wire logic [ddrp_pkg::ADDR_W-1:0]   addr,
  // Write data and masks, one half per strobe edge
  input  wire logic [ddrp_pkg::DQ_W-1:0]     dqInRise,
  input  wire logic [ddrp_pkg::DQ_W-1:0]     dqInFall,
  input  wire logic [ddrp_pkg::LANES-1:0]    dmInRise,
  input  wire logic [ddrp_pkg::LANES-1:0]    dmInFall,
  // Read data and strobes, one half per CK edge
  output logic      [ddrp_pkg::DQ_W-1:0]     dqOutRise,
  output logic      [ddrp_pkg::DQ_W-1:0]     dqOutFall,
  output logic      [ddrp_pkg::LANES-1:0]    dqOe,
  output logic      [ddrp_pkg::LANES-1:0]    dqsOutRise,
  output logic      [ddrp_pkg::LANES-1:0]    dqsOutFall,
  output logic      [ddrp_pkg::LANES-1:0]    dqsOe,
  // Link status
  output logic      [ddrp_pkg::NUM_BANKS-1:0] bankOpen,
  output logic                               linkStall,
  // Event stream to the core
  output logic                               evValid,
  input  wire logic                          evReady,
  output logic                               evBeat,
  output ddrp_pkg::ddrp_kind_t               evKind,
  output logic      [ddrp_pkg::BANK_W-1:0]   evBank,
  output logic      [ddrp_pkg::ADDR_W-1:0]   evAddr,
  output logic                               evAutoPre,
  output logic      [ddrp_pkg::WORD_W-1:0]   evData,
  output logic      [ddrp_pkg::BE_W-1:0]     evByteEn,
  // Read words from the core
  input  wire logic                          rdValid,
  input  wire logic [ddrp_pkg::WORD_W-1:0]   rdData,
  output logic                               rdReady
);
  import ddrp_pkg::*;

  typedef enum {RD_IDLE, RD_BURST} ddrp_rd_t;

  // Link reset and enable
  logic                 lRstS1_reg, linkRst, ckeQ_reg, run;
  // Command decode
  logic                 sel, isOpen, isPre, isRd, isWr;
  ddrp_kind_t           cmdKind;
  logic [ADDR_W-1:0]    cmdAddr;
  logic [COL_W-1:0]     col;
  // Write capture
  logic [1:0]           wrCyc_reg, wrCyc_next;
  logic [WORD_W-1:0]    beatData;
  logic [BE_W-1:0]      beatBe;
  logic                 beatValid;
  logic [EV_W-1:0]      evWord, evFifoData;
  logic                 evPush, evFifoReady, evFifoValid, evPop;
  // Bank state
  logic [NUM_BANKS-1:0] bankOpen_reg, bankOpen_next;
  logic                 stall_reg, stall_next;
  // Read burst
  ddrp_rd_t             rdState_reg, rdState_next;
  logic [1:0]           rdCyc_reg, rdCyc_next;
  logic [2:0]           rdPend_reg, rdPend_next;
  logic                 rdWordValid, rdPop;
  logic [WORD_W-1:0]    rdWord;
  logic [DQ_W-1:0]      dqRise_reg, dqRise_next, dqFall_reg, dqFall_next;
  logic                 drive_reg, drive_next;
  // System side
  logic                 ckeS1_reg, ckeS2_reg;
  logic                 evValid_reg, evValid_next;
  logic [EV_W-1:0]      evOut_reg, evOut_next;
  logic [2:0]           evKindBits;

  // Link reset follows the system reset through two flops
  always_ff @(posedge linkClk) begin
    lRstS1_reg <= sys_rst;
    linkRst    <= lRstS1_reg;
  end

  // Clock enable sampled each rising edge; a low sample freezes the following cycle
  always_ff @(posedge linkClk) begin
    if (linkRst) ckeQ_reg <= 1'b0;
    else ckeQ_reg <= cke;
  end
  assign run = ckeQ_reg; // RL15

  // Command decode on the rising edge of the link clock
  always_comb begin
    sel     = !csN; // RL4
    isOpen  = sel && !rasN && casN && weN; // RL7
    isPre   = sel && !rasN && casN && !weN; // RL8
    isRd    = sel && rasN && !casN && weN; // RL9
    isWr    = sel && rasN && !casN && !weN; // RL9
    // Unused top column bit stays zero in the wide organisation
    col     = {(ORG_X16 ? 1'b0 : addr[A11_BIT]), addr[COL_LO_W-1:0]}; // RL2 RL3
    cmdKind = KIND_NONE; // RL6
    cmdAddr = addr; // RL1
    if (isOpen) begin
      cmdKind = KIND_OPEN;
    end else if (isPre) begin
      cmdKind = addr[AP_BIT] ? KIND_PREALL : KIND_PRE;
    end else if (isRd || isWr) begin
      cmdKind = isRd ? KIND_RD : KIND_WR;
      cmdAddr = ADDR_W'(col);
    end
  end

  // Write beats: masked bytes are zeroed and reported as disabled
  always_comb begin
    wrCyc_next = wrCyc_reg;
    if (isWr) wrCyc_next = BURST_CYC;
    else if (wrCyc_reg != 2'h0) wrCyc_next = wrCyc_reg - 2'h1;
    beatValid = wrCyc_reg != 2'h0;
    beatBe    = ~{dmInRise, dmInFall}; // RL13 RL18
    beatData  = {dqInRise, dqInFall}; // RL14
    for (int i = 0; i < BE_W; i++) begin
      if (!beatBe[i]) beatData[i*8 +: 8] = 8'h00; // RL12
    end
    evWord = {beatValid, 3'(cmdKind), ba, cmdAddr, addr[AP_BIT], beatData, beatBe};
    evPush = run && (beatValid || cmdKind != KIND_NONE);
    // Core backlog shows on a pin rather than silently losing events
    stall_next = !evFifoReady;
  end

  // Bank tracking by bank select
  always_comb begin
    bankOpen_next = bankOpen_reg;
    if (isOpen) bankOpen_next[ba] = 1'b1; // RL16
    else if (isPre && addr[AP_BIT]) bankOpen_next = '0;
    else if (isPre) bankOpen_next[ba] = 1'b0; // RL8
    // Auto-precharge closes the bank on the read or write command itself, before its burst
    else if ((isRd || isWr) && addr[AP_BIT]) bankOpen_next[ba] = 1'b0; // RL2
  end

  // Read burst: one core word per CK cycle, high half on the rising edge
  always_comb begin
    rdState_next = rdState_reg;
    rdCyc_next   = rdCyc_reg;
    rdPend_next  = rdPend_reg;
    rdPop        = 1'b0;
    dqRise_next  = dqRise_reg;
    dqFall_next  = dqFall_reg;
    drive_next   = 1'b0;
    if (isRd && rdPend_reg != RD_PEND_MAX) rdPend_next = rdPend_reg + 3'h1;
    unique case (rdState_reg)
      RD_IDLE: begin
        if (rdPend_reg != 3'h0) begin
          rdState_next = RD_BURST;
          rdCyc_next   = BURST_CYC;
          rdPend_next  = rdPend_next - 3'h1;
        end
      end
      RD_BURST: begin
        if (rdWordValid) begin
          rdPop       = 1'b1;
          drive_next  = 1'b1;
          dqRise_next = rdWord[WORD_W-1:DQ_W];
          dqFall_next = rdWord[DQ_W-1:0];
          rdCyc_next  = rdCyc_reg - 2'h1;
          if (rdCyc_reg == 2'h1) rdState_next = RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      wrCyc_reg    <= 2'h0;
      bankOpen_reg <= '0;
      stall_reg    <= 1'b0;
      rdState_reg  <= RD_IDLE;
      rdCyc_reg    <= 2'h0;
      rdPend_reg   <= 3'h0;
      dqRise_reg   <= '0;
      dqFall_reg   <= '0;
      drive_reg    <= 1'b0;
    end else if (run) begin
      wrCyc_reg    <= wrCyc_next;
      bankOpen_reg <= bankOpen_next;
      stall_reg    <= stall_next;
      rdState_reg  <= rdState_next;
      rdCyc_reg    <= rdCyc_next;
      rdPend_reg   <= rdPend_next;
      dqRise_reg   <= dqRise_next;
      dqFall_reg   <= dqFall_next;
      drive_reg    <= drive_next;
    end
  end

  // Strobe rises with the first half and falls with the second: edge aligned
  assign dqOutRise  = dqRise_reg;
  assign dqOutFall  = dqFall_reg;
  assign dqOe       = {LANES{drive_reg}}; // RL11
  assign dqsOutRise = {LANES{drive_reg}}; // RL10
  assign dqsOutFall = '0;
  assign dqsOe      = {LANES{drive_reg}}; // RL11
  assign bankOpen   = bankOpen_reg;
  assign linkStall  = stall_reg;

  // Events cross to the core
  ddrp_async_fifo #(.WIDTH(EV_W), .DEPTH(FIFO_DEPTH)) evFifo (
    .wClk   (linkClk),
    .wRst   (linkRst),
    .wValid (evPush),
    .wData  (evWord),
    .wReady (evFifoReady),
    .rClk   (clk_sys),
    .rRst   (sys_rst),
    .rReady (evPop),
    .rValid (evFifoValid),
    .rData  (evFifoData)
  );

  // Read words cross to the link; an empty FIFO stalls the burst
  ddrp_async_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) rdFifo (
    .wClk   (clk_sys),
    .wRst   (sys_rst),
    .wValid (rdValid),
    .wData  (rdData),
    .wReady (rdReady),
    .rClk   (linkClk),
    .rRst   (linkRst),
    .rReady (rdPop && run),
    .rValid (rdWordValid),
    .rData  (rdWord)
  );

  // Clock enable brought into the system domain
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ckeS1_reg <= 1'b0;
      ckeS2_reg <= 1'b0;
    end else begin
      ckeS1_reg <= cke;
      ckeS2_reg <= ckeS1_reg;
    end
  end

  // Output stage keeps every event port on a flop
  always_comb begin
    evValid_next = evValid_reg;
    evOut_next   = evOut_reg;
    evPop        = 1'b0;
    if (ckeS2_reg && (!evValid_reg || evReady)) begin // RL15
      evValid_next = evFifoValid;
      evPop        = evFifoValid;
      if (evFifoValid) evOut_next = evFifoData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evValid_reg <= 1'b0;
      evOut_reg   <= '0;
    end else begin
      evValid_reg <= evValid_next;
      evOut_reg   <= evOut_next;
    end
  end

  assign evValid = evValid_reg;
  // Kind travels as plain bits and is cast back to its enum at the port
  assign {evBeat, evKindBits, evBank, evAddr, evAutoPre, evData, evByteEn} = evOut_reg;
  assign evKind  = ddrp_kind_t'(evKindBits);
endmodule

// ### verilog/ddrp_pkg.sv
/*
  Shared constants and types for the DDR pin command decoder.
  Assumes a sixteen-bit organisation with four banks and a fixed burst of four beats.
*/
package ddrp_pkg;

  // Pin widths
  localparam int ADDR_W    = 13;
  localparam int BANK_W    = 2;
  localparam int NUM_BANKS = 4;
  localparam int DQ_W      = 16;
  localparam int LANES     = 2;
  localparam int COL_W     = 11;
  localparam int WORD_W    = 2 * DQ_W;
  localparam int BE_W      = 2 * LANES;

  // Organisation: x16 leaves the top column bit unused
  localparam logic ORG_X16 = 1'b1;

  // Address bit positions
  localparam int AP_BIT    = 10;
  localparam int A11_BIT   = 11;
  localparam int COL_LO_W  = 10;

  // Fixed burst: four beats, two link cycles
  localparam int BURST_LEN = 4;
  localparam logic [1:0] BURST_CYC = 2'(BURST_LEN / 2);
  localparam logic [2:0] RD_PEND_MAX = 3'h7;

  // Crossing buffers
  localparam int FIFO_DEPTH = 16;

  // Event kinds handed to the core
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_OPEN,
    KIND_PRE,
    KIND_PREALL,
    KIND_RD,
    KIND_WR
  } ddrp_kind_t;

  // Event word: {beatValid, kind, bank, addr, autoPre, data, byteEn}
  localparam int EV_W = 1 + 3 + BANK_W + ADDR_W + 1 + WORD_W + BE_W;

  // Binary to gray, used on both sides of each crossing
  function automatic logic [4:0] ddrp_bin2gray(input logic [4:0] b);
    ddrp_bin2gray = b ^ (b >> 1);
  endfunction

endpackage
